//--- nvm_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_access_ctrl
  import nvm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire nvm_io_req_t io_req,
  input  wire logic        global_irq_enable,
  input  wire logic        self_program_busy,
  input  wire logic        osc_1mhz,
  output logic      [7:0]  io_rdata,
  output logic             cpu_stall,
  output logic             ready_irq
);
  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic logic [5:0] io_index(input nvm_io_req_t r);
    io_index = r.data_space ? 6'(r.addr - NVM_DATA_SPACE_OFFSET) : r.addr[5:0];
  endfunction

  function automatic logic hits(input nvm_io_req_t r, input logic [5:0] off);
    logic in_range;
    in_range = r.data_space ? (r.addr >= NVM_DATA_SPACE_OFFSET &&
                               r.addr < 8'(NVM_DATA_SPACE_OFFSET + 8'h40))
                            : (r.addr[7:6] == 2'b00);
    hits = in_range && (io_index(r) == off);
  endfunction

  logic       wr_ctl, wr_dat, wr_alo, wr_ahi;
  assign wr_ctl = io_req.wr && hits(io_req, NVM_IO_CONTROL);
  assign wr_dat = io_req.wr && hits(io_req, NVM_IO_DATA);
  assign wr_alo = io_req.wr && hits(io_req, NVM_IO_ADDR_LOW);
  assign wr_ahi = io_req.wr && hits(io_req, NVM_IO_ADDR_HIGH);

  // ----------------------------------------
  // state
  // ----------------------------------------
  nvm_state_t state;
  logic [7:0] addr_low;
  logic [2:0] addr_high;
  logic [7:0] data_byte;
  logic       irq_en;
  logic       master_en;
  logic [2:0] master_cnt;
  logic [2:0] stall_cnt;
  logic [13:0] osc_cnt;
  logic       osc_tick;
  logic [7:0] mem_rdata;
  logic       mem_wr;
  logic       busy;
  logic       start_write;
  logic       start_read;

  assign busy        = (state == NVM_PROGRAM);
  assign start_write = wr_ctl && io_req.wdata[NVM_BIT_WRITE] && master_en &&
                       !busy && !self_program_busy;
  assign start_read  = wr_ctl && io_req.wdata[NVM_BIT_READ] && !busy
                       && !start_write;
  assign mem_wr      = busy && osc_tick &&
                       (osc_cnt == 14'(NVM_WRITE_OSC_CYCLES - 1));

  nvm_tick_gen u_tick (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .osc_level (osc_1mhz),
    .osc_tick  (osc_tick)
  );

  nvm_array u_array (
    .core_clk (core_clk),
    .wr_en    (mem_wr),
    .addr     ({1'b0, addr_high, addr_low}),
    .wdata    (data_byte),
    .rdata    (mem_rdata)
  );

  // ----------------------------------------
  // address pair, no reset value
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (wr_alo && !busy) begin
      addr_low <= io_req.wdata;
    end
    if (wr_ahi && !busy) begin
      addr_high <= io_req.wdata[2:0] & NVM_ADDR_HIGH_MASK[2:0];
    end
  end

  // ----------------------------------------
  // data register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_byte <= NVM_DATA_RESET;
    end else if (start_read) begin
      data_byte <= mem_rdata;
    end else if (wr_dat && !busy) begin
      data_byte <= io_req.wdata;
    end
  end

  // ----------------------------------------
  // master enable timeout
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      master_en  <= 1'b0;
      master_cnt <= 3'h0;
    end else if (wr_ctl && io_req.wdata[NVM_BIT_MASTER]) begin
      master_en  <= 1'b1;
      master_cnt <= NVM_MASTER_CYCLES;
    end else if (master_en) begin
      master_cnt <= master_cnt - 3'h1;
      master_en  <= (master_cnt != 3'h1);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_en <= NVM_CONTROL_RESET[NVM_BIT_IRQEN];
    end else if (wr_ctl) begin
      irq_en <= io_req.wdata[NVM_BIT_IRQEN];
    end
  end

  // ----------------------------------------
  // write sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state   <= NVM_IDLE;
      osc_cnt <= 14'h0000;
    end else begin
      case (state)
        NVM_IDLE: begin
          osc_cnt <= 14'h0000;
          if (start_write) begin
            state <= NVM_PROGRAM;
          end
        end
        NVM_PROGRAM: begin
          if (osc_tick) begin
            osc_cnt <= osc_cnt + 14'h0001;
          end
          if (mem_wr) begin
            state <= NVM_IDLE;
          end
        end
        default: state <= NVM_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // processor stall
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_cnt <= 3'h0;
      cpu_stall <= 1'b0;
    end else if (start_write) begin
      stall_cnt <= NVM_WRITE_STALL - 3'h1;
      cpu_stall <= 1'b1;
    end else if (start_read) begin
      stall_cnt <= NVM_READ_STALL - 3'h1;
      cpu_stall <= 1'b1;
    end else if (stall_cnt != 3'h0) begin
      stall_cnt <= stall_cnt - 3'h1;
      cpu_stall <= 1'b1;
    end else begin
      cpu_stall <= 1'b0;
    end
  end

  // ----------------------------------------
  // read-back and interrupt
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
    end else if (io_req.rd) begin
      if (hits(io_req, NVM_IO_CONTROL)) begin
        io_rdata <= {4'h0, irq_en, master_en, busy, 1'b0};
      end else if (hits(io_req, NVM_IO_DATA)) begin
        io_rdata <= data_byte;
      end else if (hits(io_req, NVM_IO_ADDR_LOW)) begin
        io_rdata <= addr_low;
      end else if (hits(io_req, NVM_IO_ADDR_HIGH)) begin
        io_rdata <= {5'h00, addr_high};
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= irq_en && global_irq_enable && !busy && !start_write;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_master_expire;
    @(posedge core_clk) disable iff (!reset_n)
      (wr_ctl && io_req.wdata[NVM_BIT_MASTER])
      ##1 (!(wr_ctl && io_req.wdata[NVM_BIT_MASTER]))[*4] |=> !master_en;
  endproperty
  a_master_expire: assert property (p_master_expire) else $error("master enable not expired");

  property p_no_write_without_master;
    @(posedge core_clk) disable iff (!reset_n)
      (!master_en && state == NVM_IDLE) |=> state == NVM_IDLE;
  endproperty
  a_no_write_without_master: assert property (p_no_write_without_master) else $error("write without master");

  property p_write_start;
    @(posedge core_clk) disable iff (!reset_n)
      (wr_ctl && io_req.wdata[NVM_BIT_WRITE] && master_en && !busy && !self_program_busy)
      |=> busy;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write not started");

  property p_flash_busy;
    @(posedge core_clk) disable iff (!reset_n)
      (self_program_busy && !busy) |=> !busy;
  endproperty
  a_flash_busy: assert property (p_flash_busy) else $error("write during flash programming");

  property p_write_stall;
    @(posedge core_clk) disable iff (!reset_n)
      start_write |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall;
  endproperty
  a_write_stall: assert property (p_write_stall) else $error("write stall length wrong");

  property p_read_stall;
    @(posedge core_clk) disable iff (!reset_n)
      start_read |=> cpu_stall[*4] ##1 !cpu_stall;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall length wrong");

  property p_read_data;
    @(posedge core_clk) disable iff (!reset_n)
      start_read |=> data_byte == $past(mem_rdata);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not loaded");

  property p_addr_frozen;
    @(posedge core_clk) disable iff (!reset_n)
      (busy && $past(busy)) |-> $stable(addr_low) && $stable(addr_high);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address changed while writing");

  property p_irq_level;
    @(posedge core_clk) disable iff (!reset_n)
      (irq_en && global_irq_enable && !busy && !start_write) |=> ready_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("ready interrupt missing");

  property p_write_end;
    @(posedge core_clk) disable iff (!reset_n)
      mem_wr |=> !busy;
  endproperty
  a_write_end: assert property (p_write_end) else $error("strobe not cleared at end");

  property p_master_hold;
    @(posedge core_clk) disable iff (!reset_n)
      (wr_ctl && io_req.wdata[NVM_BIT_MASTER]) |=> master_en[*4];
  endproperty
  a_master_hold: assert property (p_master_hold) else $error("master window too short");

  property p_master_idle;
    @(posedge core_clk) disable iff (!reset_n)
      (!master_en && !(wr_ctl && io_req.wdata[NVM_BIT_MASTER])) |=> !master_en;
  endproperty
  a_master_idle: assert property (p_master_idle) else $error("master enable set itself");

  property p_busy_hold;
    @(posedge core_clk) disable iff (!reset_n)
      (busy && !mem_wr) |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("strobe dropped early");

  property p_osc_hold;
    @(posedge core_clk) disable iff (!reset_n)
      (busy && !osc_tick) |=> $stable(osc_cnt);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("write timer moved without tick");

  property p_osc_clear;
    @(posedge core_clk) disable iff (!reset_n)
      !busy |=> osc_cnt == 14'h0000;
  endproperty
  a_osc_clear: assert property (p_osc_clear) else $error("write timer not cleared");

  property p_irq_off_busy;
    @(posedge core_clk) disable iff (!reset_n)
      busy |=> !ready_irq;
  endproperty
  a_irq_off_busy: assert property (p_irq_off_busy) else $error("interrupt while writing");

  property p_irq_off_global;
    @(posedge core_clk) disable iff (!reset_n)
      !global_irq_enable |=> !ready_irq;
  endproperty
  a_irq_off_global: assert property (p_irq_off_global) else $error("interrupt while masked");

  property p_read_ignored;
    @(posedge core_clk) disable iff (!reset_n)
      (busy && wr_ctl && io_req.wdata[NVM_BIT_READ]) |=> $stable(data_byte);
  endproperty
  a_read_ignored: assert property (p_read_ignored) else $error("read taken while writing");

  property p_addr_low_load;
    @(posedge core_clk) disable iff (!reset_n)
      (wr_alo && !busy) |=> addr_low == $past(io_req.wdata);
  endproperty
  a_addr_low_load: assert property (p_addr_low_load) else $error("low address not loaded");

  property p_data_load;
    @(posedge core_clk) disable iff (!reset_n)
      (wr_dat && !busy && !start_read) |=> data_byte == $past(io_req.wdata);
  endproperty
  a_data_load: assert property (p_data_load) else $error("data byte not loaded");

  property p_stall_idle;
    @(posedge core_clk) disable iff (!reset_n)
      (!start_write && !start_read && stall_cnt == 3'h0) |=> !cpu_stall;
  endproperty
  a_stall_idle: assert property (p_stall_idle) else $error("stall without strobe");

  property p_high_read_zero;
    @(posedge core_clk) disable iff (!reset_n)
      (io_req.rd && hits(io_req, NVM_IO_ADDR_HIGH)) |=> io_rdata[7:3] == 5'h00;
  endproperty
  a_high_read_zero: assert property (p_high_read_zero) else $error("unused address bits set");

  property p_control_read;
    @(posedge core_clk) disable iff (!reset_n)
      (io_req.rd && hits(io_req, NVM_IO_CONTROL)) |=> io_rdata[NVM_BIT_WRITE] == $past(busy);
  endproperty
  a_control_read: assert property (p_control_read) else $error("strobe readback wrong");
endmodule
`default_nettype wire

//--- nvm_pkg.sv
// Operation
// - linear 11-bit address from low/high pair
// - data register holds write byte, read result
// - ready interrupt while strobe clear, enabled
// - write only if strobe within four cycles
// - strobe ignored while master enable zero
// - master enable self-clears after four cycles
// - no write during flash self-programming
// - strobe stays set until write completes
// - accepted write stalls processor two cycles
// - read strobe fetches byte immediately
// - read stalls processor four cycles
// - reads and address changes blocked while writing
// - write time counted on 1 MHz oscillator
// - registers at I/O 0x1C-0x1F, data +0x20
package nvm_pkg;
  localparam logic [5:0] NVM_IO_CONTROL   = 6'h1c;
  localparam logic [5:0] NVM_IO_DATA      = 6'h1d;
  localparam logic [5:0] NVM_IO_ADDR_LOW  = 6'h1e;
  localparam logic [5:0] NVM_IO_ADDR_HIGH = 6'h1f;
  localparam logic [7:0] NVM_DATA_SPACE_OFFSET = 8'h20;
  localparam int NVM_BIT_READ   = 0;
  localparam int NVM_BIT_WRITE  = 1;
  localparam int NVM_BIT_MASTER = 2;
  localparam int NVM_BIT_IRQEN  = 3;
  localparam int NVM_ADDR_WIDTH = 12;
  localparam int NVM_DEPTH      = 4096;
  localparam logic [7:0] NVM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] NVM_DATA_RESET    = 8'h00;
  localparam logic [3:0] NVM_ADDR_HIGH_MASK = 4'h7;
  localparam logic [2:0] NVM_MASTER_CYCLES = 3'h4;
  localparam logic [2:0] NVM_WRITE_STALL   = 3'h2;
  localparam logic [2:0] NVM_READ_STALL    = 3'h4;
  localparam int NVM_WRITE_OSC_CYCLES = 8448;
  localparam int NVM_OSC_FREQ_HZ      = 1000000;
  typedef enum {NVM_IDLE, NVM_PROGRAM} nvm_state_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       data_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvm_io_req_t;
endpackage

//--- nvm_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// oscillator edge detector
// ----------------------------------------
module nvm_tick_gen
  import nvm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic osc_level,
  output logic      osc_tick
);
  logic meta;
  logic sync;
  logic prev;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= osc_level;
      sync <= meta;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev     <= 1'b0;
      osc_tick <= 1'b0;
    end else begin
      prev     <= sync;
      osc_tick <= sync & ~prev;
    end
  end
endmodule
`default_nettype wire

//--- nvm_array.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// byte array storage
// ----------------------------------------
module nvm_array
  import nvm_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      wr_en,
  input  wire logic [NVM_ADDR_WIDTH-1:0] addr,
  input  wire logic [7:0]                wdata,
  output logic      [7:0]                rdata
);
  logic [7:0] mem [NVM_DEPTH];
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end
  assign rdata = mem[addr];
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nvm_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        core_clk;
  logic        reset_n;
  nvm_io_req_t io_req;
  logic        global_irq_enable;
  logic        self_program_busy;
  logic        osc_1mhz;
  logic [7:0]  io_rdata;
  logic        cpu_stall;
  logic        ready_irq;
  int          mismatches;
  int          checks_done;

  nvm_access_ctrl uut (
    .core_clk          (core_clk),
    .reset_n           (reset_n),
    .io_req            (io_req),
    .global_irq_enable (global_irq_enable),
    .self_program_busy (self_program_busy),
    .osc_1mhz          (osc_1mhz),
    .io_rdata          (io_rdata),
    .cpu_stall         (cpu_stall),
    .ready_irq         (ready_irq)
  );

  always #50 core_clk = ~core_clk;
  // fast oscillator keeps the write short
  always @(posedge core_clk) #1 osc_1mhz = ~osc_1mhz;

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_int(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      mismatches++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic io(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_req = '{wr: wr, rd: rd, data_space: a[5], addr: a, wdata: d};
    @(posedge core_clk);
    #1;
    io_req = '0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    io(1'b1, 1'b0, a, d);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    io(1'b0, 1'b1, a, 8'h00);
    chk_byte(io_rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // stalled cycles seen over the next eight
  task automatic stall_cnt(input int exp);
    int n;
    n = 0;
    repeat (8) begin
      @(negedge core_clk);
      if (cpu_stall === 1'b1) n++;
    end
    @(posedge core_clk);
    #1;
    chk_int(n, exp);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_reg(8'h1c, 8'h00);
    rd_reg(8'h3d, 8'h00);
    rd_reg(8'h10, 8'h00);
    chk_flag(ready_irq, 1'b0);
  endtask

  task automatic t_addr();
    wr_reg(8'h1f, 8'hff);
    wr_reg(8'h1e, 8'hff);
    rd_reg(8'h1f, 8'h07);
    rd_reg(8'h1e, 8'hff);
    wr_reg(8'h1d, 8'ha5);
    rd_reg(8'h1d, 8'ha5);
  endtask

  task automatic t_refuse();
    wr_reg(8'h1c, 8'h02);
    stall_cnt(0);
    rd_reg(8'h1c, 8'h00);
    self_program_busy = 1'b1;
    wr_reg(8'h1c, 8'h04);
    wr_reg(8'h1c, 8'h02);
    stall_cnt(0);
    rd_reg(8'h1c, 8'h00);
    self_program_busy = 1'b0;
    wr_reg(8'h1c, 8'h04);
    rd_reg(8'h1c, 8'h04);
    idle(1);
    wr_reg(8'h1c, 8'h02);
    stall_cnt(0);
    rd_reg(8'h1c, 8'h00);
  endtask

  task automatic t_write();
    int  i;
    int  n;
    time t0;
    rd_reg(8'h1c, 8'h00);
    global_irq_enable = 1'b0;
    wr_reg(8'h1c, 8'h0c);
    idle(2);
    wr_reg(8'h1c, 8'h0a);
    t0 = $time;
    stall_cnt(2);
    global_irq_enable = 1'b1;
    chk_flag(ready_irq, 1'b0);
    wr_reg(8'h1c, 8'h09);
    wr_reg(8'h1e, 8'h00);
    wr_reg(8'h1d, 8'h00);
    rd_reg(8'h1c, 8'h0a);
    rd_reg(8'h1e, 8'hff);
    rd_reg(8'h1d, 8'ha5);
    for (i = 0; i < 20000 && ready_irq !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (ready_irq !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    // one oscillator period is two clock cycles here
    n = int'(($time - t0) / 100);
    chk_flag(n >= 2 * NVM_WRITE_OSC_CYCLES && n <= 2 * NVM_WRITE_OSC_CYCLES + 1, 1'b1);
    rd_reg(8'h1c, 8'h08);
    chk_flag(ready_irq, 1'b1);
  endtask

  task automatic t_read();
    wr_reg(8'h3d, 8'h5a);
    wr_reg(8'h3c, 8'h09);
    stall_cnt(4);
    rd_reg(8'h3d, 8'ha5);
    global_irq_enable = 1'b0;
    idle(2);
    chk_flag(ready_irq, 1'b0);
    global_irq_enable = 1'b1;
    wr_reg(8'h1c, 8'h00);
    idle(2);
    chk_flag(ready_irq, 1'b0);
    reset_n = 1'b0;
    idle(2);
    reset_n = 1'b1;
    rd_reg(8'h3d, 8'h00);
    rd_reg(8'h1c, 8'h00);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    io_req = '0;
    global_irq_enable = 1'b1;
    self_program_busy = 1'b0;
    osc_1mhz = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_addr();
    t_refuse();
    t_write();
    t_read();
    finish_test();
  end
endmodule
`default_nettype wire
